// ==== fpc_params.svh ====
// Purpose: constants for the floating point mode and control/status registers
// Assumes: control registers are addressed by the 5-bit coprocessor control index
// Notes: indices are register numbers, not byte addresses
`ifndef FPC_PARAMS_SVH
`define FPC_PARAMS_SVH

`define FPC_IDX_IMPL 5'h00
`define FPC_IDX_COMPANION 5'h01
`define FPC_IDX_MODE_SET 5'h04
`define FPC_IDX_CTRL 5'h1F

`define FPC_ZERO_REG 5'h00

`define FPC_IMPL_SWITCH_BIT 28
`define FPC_SWITCH_PRESENT 1'h1

`define FPC_CTRL_CC_HI_MSB 31
`define FPC_CTRL_CC_HI_LSB 25
`define FPC_CTRL_FLUSH_BIT 24
`define FPC_CTRL_CC0_BIT 23
`define FPC_CTRL_IMPL_MSB 22
`define FPC_CTRL_IMPL_LSB 21
`define FPC_CTRL_RSVD_BIT 20

`define FPC_IMPL_PRESENT 1'h0

`define FPC_MODE_RESET 1'h0
`define FPC_CC_RESET 8'h00
`define FPC_FLUSH_RESET 1'h0
`define FPC_IMPL_RESET 2'h0

`define FPC_DP_MSB 63
`define FPC_EXP_MSB 62
`define FPC_EXP_LSB 52
`define FPC_FRAC_MSB 51

`endif

// ==== fpc_pkg.sv ====
// Purpose: types shared by the mode and control/status register logic
// Assumes: all widths are literals in this file; fpc_params.svh is not included
// Notes: none
`default_nettype none
package fpc_pkg;

    // one coprocessor control-register move, read or write
    typedef struct packed {
        logic valid;
        logic write;
        logic [4:0] index;
        logic [4:0] src_reg;
        logic [31:0] wdata;
    } fpc_req_t;

    typedef struct packed {
        logic valid;
        logic [31:0] rdata;
        logic exc_reserved_instr;
        logic exc_cop_unusable;
    } fpc_resp_t;

    typedef struct packed {
        logic [63:0] value;
        logic flushed;
    } fpc_flush_t;

    typedef struct packed {
        logic fp_register_mode_bit;
        logic [7:0] fp_condition_codes;
        logic flush_subnormals;
        logic [1:0] impl_bits;
        fpc_resp_t resp;
        logic cc_test;
        logic unimpl_exc;
    } fpc_state_t;

endpackage
`default_nettype wire

// ==== fpc_flush.sv ====
// Purpose: replaces a subnormal or tiny double-precision value by a signed zero
// Assumes: tiny_in marks a tiny non-zero result from the rounding stage
// Notes: one cycle of latency, value and flag both registered
`include "fpc_params.svh"
`default_nettype none
module fpc_flush (
    // clock and reset
    input wire logic mclk,
    input wire logic reset,
    // control
    input wire logic flush_en,
    input wire logic tiny_in,
    // data
    input wire logic [63:0] value_in,
    output fpc_pkg::fpc_flush_t out
);
    fpc_pkg::fpc_flush_t state_reg;
    fpc_pkg::fpc_flush_t state_next;
    logic subnormal;
    logic hit;

    assign subnormal = (value_in[`FPC_EXP_MSB:`FPC_EXP_LSB] == 11'h000)
        && (value_in[`FPC_FRAC_MSB:0] != 52'h0);

    always_comb
    begin
        hit = flush_en && (subnormal || tiny_in);
        state_next.flushed = hit;
        state_next.value = hit ? {value_in[`FPC_DP_MSB], 63'h0} : value_in;
    end

    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
            state_reg <= '0;
        else
            state_reg <= state_next;
    end

    assign out = state_reg;
endmodule
`default_nettype wire

// ==== fpc_regs.sv ====
// Purpose: register mode aliases and the upper control part of the control/status register
// Assumes: the core presents each control-register move as a one-cycle request
// Notes: answers come one cycle after the request; mode bit drives the register file
`include "fpc_params.svh"
`default_nettype none
// Function
// - write of zero register to mode-set alias sets the register mode bit
// - mode-set alias write from any other register raises reserved instruction, no change
// - implementation register read shows the user mode switch presence bit
// - mode-set alias is write-only, holds nothing; reading it returns zero
// - control/status register open to any program while the coprocessor is enabled
// - condition codes at 31:25 and 23, read/write, selectable by branches and moves
// - flush control clear: subnormals untouched, unimplemented operation may be signalled
// - flush control set: tiny results become signed zero, no unimplemented exception
// - flush control set: subnormal input operands become signed zero first
// - bit 20 reserved, read-only, always reads zero
// - companion register reads the mode bit; zero register write clears it
module fpc_regs (
    // clock and reset
    input wire logic mclk,
    input wire logic reset,
    // control-register moves
    input wire fpc_pkg::fpc_req_t req,
    input wire logic cop1_enable,
    output fpc_pkg::fpc_resp_t resp,
    // mode and control to the datapath
    output logic fp_register_mode_bit,
    output logic flush_subnormals,
    // condition code test for branches and conditional moves
    input wire logic cc_test_req,
    input wire logic [2:0] cc_sel,
    output logic cc_test,
    // unimplemented operation from the datapath
    input wire logic unimpl_req,
    output logic unimpl_exc,
    // operand and result flushing
    input wire logic [63:0] operand_in,
    output fpc_pkg::fpc_flush_t operand_out,
    input wire logic [63:0] result_in,
    input wire logic result_tiny,
    output fpc_pkg::fpc_flush_t result_out
);
    fpc_pkg::fpc_state_t state_reg;
    fpc_pkg::fpc_state_t state_next;
    logic from_zero;
    logic [31:0] ctrl_view;

    assign from_zero = (req.src_reg == `FPC_ZERO_REG);

    always_comb
    begin
        ctrl_view = 32'h0;
        ctrl_view[`FPC_CTRL_CC_HI_MSB:`FPC_CTRL_CC_HI_LSB] =
            state_reg.fp_condition_codes[7:1];
        ctrl_view[`FPC_CTRL_CC0_BIT] = state_reg.fp_condition_codes[0];
        ctrl_view[`FPC_CTRL_FLUSH_BIT] = state_reg.flush_subnormals;
        ctrl_view[`FPC_CTRL_IMPL_MSB:`FPC_CTRL_IMPL_LSB] = state_reg.impl_bits;
        ctrl_view[`FPC_CTRL_RSVD_BIT] = 1'h0;
    end

    always_comb
    begin
        state_next = state_reg;
        state_next.resp = '0;
        state_next.cc_test = state_reg.cc_test;
        if (cc_test_req)
            state_next.cc_test = state_reg.fp_condition_codes[cc_sel];
        state_next.unimpl_exc = unimpl_req && !state_reg.flush_subnormals;
        if (req.valid)
        begin
            state_next.resp.valid = 1'h1;
            if (!cop1_enable)
                state_next.resp.exc_cop_unusable = 1'h1;
            else if (req.write)
            begin
                case (req.index)
                    `FPC_IDX_MODE_SET:
                    begin
                        if (from_zero)
                            state_next.fp_register_mode_bit = 1'h1;
                        else
                            state_next.resp.exc_reserved_instr = 1'h1;
                    end
                    `FPC_IDX_COMPANION:
                    begin
                        if (from_zero)
                            state_next.fp_register_mode_bit = 1'h0;
                        else
                            state_next.resp.exc_reserved_instr = 1'h1;
                    end
                    `FPC_IDX_CTRL:
                    begin
                        state_next.fp_condition_codes = {
                            req.wdata[`FPC_CTRL_CC_HI_MSB:`FPC_CTRL_CC_HI_LSB],
                            req.wdata[`FPC_CTRL_CC0_BIT]};
                        state_next.flush_subnormals = req.wdata[`FPC_CTRL_FLUSH_BIT];
                        if (`FPC_IMPL_PRESENT)
                            state_next.impl_bits =
                                req.wdata[`FPC_CTRL_IMPL_MSB:`FPC_CTRL_IMPL_LSB];
                    end
                    default:
                    begin
                        state_next.resp.valid = 1'h1;
                    end
                endcase
            end
            else
            begin
                case (req.index)
                    `FPC_IDX_IMPL:
                        state_next.resp.rdata[`FPC_IMPL_SWITCH_BIT] = `FPC_SWITCH_PRESENT;
                    `FPC_IDX_COMPANION:
                        state_next.resp.rdata = {31'h0, state_reg.fp_register_mode_bit};
                    `FPC_IDX_CTRL:
                        state_next.resp.rdata = ctrl_view;
                    default:
                        state_next.resp.rdata = 32'h0;
                endcase
            end
        end
    end

    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            state_reg <= '0;
            state_reg.fp_register_mode_bit <= `FPC_MODE_RESET;
            state_reg.fp_condition_codes <= `FPC_CC_RESET;
            state_reg.flush_subnormals <= `FPC_FLUSH_RESET;
            state_reg.impl_bits <= `FPC_IMPL_RESET;
        end
        else
            state_reg <= state_next;
    end

    assign resp = state_reg.resp;
    assign fp_register_mode_bit = state_reg.fp_register_mode_bit;
    assign flush_subnormals = state_reg.flush_subnormals;
    assign cc_test = state_reg.cc_test;
    assign unimpl_exc = state_reg.unimpl_exc;

    // operand flushing before the operation, result flushing after rounding
    fpc_flush u_operand_flush (
        .mclk(mclk),
        .reset(reset),
        .flush_en(state_reg.flush_subnormals),
        .tiny_in(1'h0),
        .value_in(operand_in),
        .out(operand_out)
    );

    fpc_flush u_result_flush (
        .mclk(mclk),
        .reset(reset),
        .flush_en(state_reg.flush_subnormals),
        .tiny_in(result_tiny),
        .value_in(result_in),
        .out(result_out)
    );

    property p_set_mode;
        @(posedge mclk) disable iff (reset)
        req.valid && req.write && cop1_enable && req.index == `FPC_IDX_MODE_SET && from_zero
        |=> fp_register_mode_bit && resp.valid && !resp.exc_reserved_instr;
    endproperty
    a_set_mode: assert property (p_set_mode) else $error("mode set failed");

    property p_bad_src;
        @(posedge mclk) disable iff (reset)
        req.valid && req.write && cop1_enable && req.index == `FPC_IDX_MODE_SET && !from_zero
        |=> resp.exc_reserved_instr && $stable(fp_register_mode_bit);
    endproperty
    a_bad_src: assert property (p_bad_src) else $error("bad source not trapped");

    property p_impl_read;
        @(posedge mclk) disable iff (reset)
        req.valid && !req.write && cop1_enable && req.index == `FPC_IDX_IMPL
        |=> resp.rdata[`FPC_IMPL_SWITCH_BIT] == `FPC_SWITCH_PRESENT;
    endproperty
    a_impl_read: assert property (p_impl_read) else $error("presence bit wrong");

    property p_disabled;
        @(posedge mclk) disable iff (reset)
        req.valid && !cop1_enable
        |=> resp.exc_cop_unusable && $stable(fp_register_mode_bit) && $stable(flush_subnormals);
    endproperty
    a_disabled: assert property (p_disabled) else $error("disabled access acted");

    property p_flush_write;
        @(posedge mclk) disable iff (reset)
        req.valid && req.write && cop1_enable && req.index == `FPC_IDX_CTRL
        |=> flush_subnormals == $past(req.wdata[`FPC_CTRL_FLUSH_BIT]);
    endproperty
    a_flush_write: assert property (p_flush_write) else $error("flush control not written");

    property p_cc_test;
        @(posedge mclk) disable iff (reset)
        cc_test_req |=> cc_test == $past(state_reg.fp_condition_codes[cc_sel]);
    endproperty
    a_cc_test: assert property (p_cc_test) else $error("condition code test wrong");

    property p_unimpl;
        @(posedge mclk) disable iff (reset)
        unimpl_req ##1 unimpl_exc |-> !$past(flush_subnormals);
    endproperty
    a_unimpl: assert property (p_unimpl) else $error("unimplemented raised while flushing");

    property p_result_flush;
        @(posedge mclk) disable iff (reset)
        flush_subnormals && result_tiny
        |=> result_out.flushed && result_out.value[`FPC_EXP_MSB:0] == 63'h0;
    endproperty
    a_result_flush: assert property (p_result_flush) else $error("tiny result kept");

    property p_ctrl_fixed;
        @(posedge mclk) disable iff (reset)
        req.valid && !req.write && cop1_enable && req.index == `FPC_IDX_CTRL
        |=> resp.rdata[`FPC_CTRL_RSVD_BIT] == 1'h0
            && resp.rdata[`FPC_CTRL_IMPL_MSB:`FPC_CTRL_IMPL_LSB] == 2'h0
            && resp.rdata[`FPC_CTRL_RSVD_BIT - 1:0] == 20'h0;
    endproperty
    a_ctrl_fixed: assert property (p_ctrl_fixed) else $error("fixed bits not zero");

    property p_clear_mode;
        @(posedge mclk) disable iff (reset)
        req.valid && req.write && cop1_enable && req.index == `FPC_IDX_COMPANION && from_zero
        ##1 req.valid && !req.write && cop1_enable && req.index == `FPC_IDX_COMPANION
        |=> resp.rdata == 32'h0;
    endproperty
    a_clear_mode: assert property (p_clear_mode) else $error("companion clear not seen");
endmodule
`default_nettype wire

// ==== fpc_regs_tb.sv ====
// Purpose: self-checking bench for the mode aliases and control/status register
// Assumes: one request per cycle, answer and mode bit one cycle later
// Notes: random control/status writes from a fixed seed, corner values first
`include "fpc_params.svh"
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk, reset, cop1_enable, cc_test_req, unimpl_req, result_tiny;
    logic [2:0] cc_sel;
    logic [63:0] operand_in, result_in, v;
    fpc_pkg::fpc_req_t req;
    fpc_pkg::fpc_resp_t resp, r;
    fpc_pkg::fpc_flush_t operand_out, result_out;
    logic fp_register_mode_bit, flush_subnormals, cc_test, unimpl_exc, fl;
    logic [31:0] w;
    integer seed = 20;
    integer miscompares = 0;
    integer samples_checked = 0;
    integer i, n;
    fpc_regs dut_u (.mclk(mclk), .reset(reset), .req(req), .cop1_enable(cop1_enable),
        .resp(resp), .fp_register_mode_bit(fp_register_mode_bit),
        .flush_subnormals(flush_subnormals), .cc_test_req(cc_test_req), .cc_sel(cc_sel),
        .cc_test(cc_test), .unimpl_req(unimpl_req), .unimpl_exc(unimpl_exc),
        .operand_in(operand_in), .operand_out(operand_out), .result_in(result_in),
        .result_tiny(result_tiny), .result_out(result_out));
    initial
    begin
        mclk = 1'h0;
        forever #2 mclk = ~mclk;
    end
    // readable part of the control/status register
    function automatic logic [31:0] ctrl_view(input logic [31:0] d);
        return {d[31:23], 23'h000000};
    endfunction
    task automatic chk(input string name, input logic [63:0] e, input logic [63:0] g);
        samples_checked++;
        if (g !== e)
        begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", name, e, g);
        end
    endtask
    task automatic xfer(input logic wr, input logic [4:0] idx, input logic [4:0] src,
        input logic [31:0] wd);
        req = '{valid: 1'h1, write: wr, index: idx, src_reg: src, wdata: wd};
        @(posedge mclk);
        #1;
        r = resp;
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // tests take about 300 cycles; wide margin before giving up
    initial
    begin
        #20000;
        miscompares++;
        test_done;
    end
    initial
    begin
        reset = 1'h1;
        req = '0;
        cop1_enable = 1'h1;
        cc_test_req = 1'h0;
        cc_sel = 3'h0;
        unimpl_req = 1'h0;
        result_tiny = 1'h0;
        operand_in = 64'h0;
        result_in = 64'h0;
        repeat (4) @(posedge mclk);
        #1;
        reset = 1'h0;
        xfer(1'h0, `FPC_IDX_CTRL, 5'h00, 32'h0);
        chk("resp_valid", 1, r.valid);
        chk("ctrl_reset", 0, r.rdata);
        xfer(1'h1, `FPC_IDX_MODE_SET, `FPC_ZERO_REG, 32'h0);
        chk("mode_set", 1, fp_register_mode_bit);
        chk("no_exc", 0, r.exc_reserved_instr);
        xfer(1'h0, `FPC_IDX_COMPANION, 5'h00, 32'h0);
        chk("comp_read", 1, r.rdata);
        xfer(1'h1, `FPC_IDX_COMPANION, `FPC_ZERO_REG, 32'h0);
        chk("mode_clr", 0, fp_register_mode_bit);
        xfer(1'h0, `FPC_IDX_COMPANION, 5'h00, 32'h0);
        chk("comp_next", 0, r.rdata);
        xfer(1'h1, `FPC_IDX_MODE_SET, 5'h07, 32'h0);
        chk("set_bad_exc", 1, r.exc_reserved_instr);
        chk("set_bad_mode", 0, fp_register_mode_bit);
        xfer(1'h1, `FPC_IDX_MODE_SET, `FPC_ZERO_REG, 32'h0);
        xfer(1'h1, `FPC_IDX_COMPANION, 5'h1F, 32'h0);
        chk("comp_bad_exc", 1, r.exc_reserved_instr);
        chk("comp_bad_mode", 1, fp_register_mode_bit);
        // the mode-set alias is never read; an unmapped write is only acknowledged
        xfer(1'h1, 5'h02, 5'h03, 32'h0);
        chk("unmapped_exc", 0, r.exc_reserved_instr);
        chk("unmapped_mode", 1, fp_register_mode_bit);
        xfer(1'h0, `FPC_IDX_IMPL, 5'h00, 32'h0);
        chk("impl_present", 32'h1000_0000, r.rdata);
        cop1_enable = 1'h0;
        xfer(1'h1, `FPC_IDX_CTRL, 5'h01, 32'hFFFF_FFFF);
        chk("cop_unusable", 1, r.exc_cop_unusable);
        xfer(1'h1, `FPC_IDX_COMPANION, `FPC_ZERO_REG, 32'h0);
        chk("cop_mode_kept", 1, fp_register_mode_bit);
        cop1_enable = 1'h1;
        xfer(1'h0, `FPC_IDX_CTRL, 5'h00, 32'h0);
        chk("cop_ctrl_kept", 0, r.rdata);
        for (i = 0; i < 24; i++)
        begin
            w = (i == 0) ? 32'hFFFF_FFFF : (i == 1) ? 32'h0 : $random(seed);
            xfer(1'h1, `FPC_IDX_CTRL, 5'h02, w);
            xfer(1'h0, `FPC_IDX_CTRL, 5'h00, 32'h0);
            chk("ctrl_read", ctrl_view(w), r.rdata);
            chk("fs_out", w[24], flush_subnormals);
            req.valid = 1'h0;
            cc_test_req = 1'h1;
            for (n = 0; n < 8; n++)
            begin
                cc_sel = n[2:0];
                @(posedge mclk);
                #1;
                chk("cc_test", (n == 0) ? w[23] : w[24 + n], cc_test);
            end
            cc_test_req = 1'h0;
            v = {$random(seed), $random(seed)};
            v[62:52] = i[0] ? 11'h000 : 11'h3FF;
            fl = w[24] & i[0];
            operand_in = v;
            result_in = v;
            result_tiny = i[0];
            unimpl_req = 1'h1;
            @(posedge mclk);
            #1;
            unimpl_req = 1'h0;
            chk("unimpl_exc", !w[24], unimpl_exc);
            chk("op_val", fl ? {v[63], 63'h0} : v, operand_out.value);
            chk("op_flag", fl, operand_out.flushed);
            chk("res_val", fl ? {v[63], 63'h0} : v, result_out.value);
            chk("res_flag", fl, result_out.flushed);
        end
        test_done;
    end
endmodule
`default_nettype wire
